// >>> hw/logic_shift_bit_unit.sv
// Byte-wide execution unit for logic, shift, rotate and single-bit instructions.
// Assumes the decoder supplies operands and the current carry, and applies the returned
// result and flags to the register file and condition codes before its next request.
//
// Summary of operation
// - AND destination with register or immediate byte.
// - OR destination with register or immediate byte.
// - XOR destination with register or immediate byte.
// - Complement every bit of destination register.
// - Arithmetic shift left or right, written back.
// - Logical shift left or right, written back.
// - Rotate left or right, wrapping end bit.
// - Rotate through carry as nine-bit ring.
// - Set selected bit to one.
// - Clear selected bit to zero.
// - Invert selected bit and write back.
// - Zero flag gets inverse of selected bit.
// - Bit number from immediate or register low bits.
// - Inverted carry, load, store: immediate bit only.
// - Carry becomes carry AND selected bit.
// - Carry becomes carry AND inverted bit.
// - Carry becomes carry OR selected bit.
// - Carry becomes carry OR inverted bit.
// - Carry becomes carry XOR selected bit.
// - Carry becomes carry XOR inverted bit.
// - Load bit, or its inverse, into carry.
// - Store carry, or its inverse, into bit.
module logic_shift_bit_unit
  import logic_shift_bit_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic              i_req_valid,
  output logic                   o_req_ready,
  input  wire alu_req_t          i_req,
  output logic                   o_resp_valid,
  output alu_resp_t              o_resp,
  output logic                   o_mem_valid,
  output mem_cmd_t               o_mem_cmd,
  input  wire logic              i_mem_ack,
  input  wire logic [DATA_W-1:0] i_mem_rdata
);

  typedef enum logic [1:0] {
    st_idle,
    st_mem_read,
    st_mem_write
  } state_t;

  // True for operations that take their bit number from the instruction only.
  function automatic logic is_inverted_form(input op_t op);
    unique case (op)
      carry_and_inverted_bit,
      carry_or_inverted_bit,
      carry_xor_inverted_bit,
      load_inverted_bit_to_carry,
      store_inverted_carry_to_bit: is_inverted_form = 1'b1;
      default:                     is_inverted_form = 1'b0;
    endcase
  endfunction

  // True for operations that work on one bit and may address memory.
  function automatic logic is_bit_op(input op_t op);
    is_bit_op = (op >= set_selected_bit) && (op <= store_inverted_carry_to_bit);
  endfunction

  // True for bit operations that change the operand byte.
  function automatic logic modifies_operand(input op_t op);
    unique case (op)
      set_selected_bit,
      clear_selected_bit,
      invert_selected_bit,
      store_carry_to_bit,
      store_inverted_carry_to_bit: modifies_operand = 1'b1;
      default:                     modifies_operand = 1'b0;
    endcase
  endfunction

  // Requests the unit refuses: a register-held bit number on an inverted form,
  // or a memory operand on a register-only operation.
  function automatic logic is_illegal(input alu_req_t req);
    is_illegal = (is_inverted_form(req.op) && req.bit_from_register) ||
                 (req.operand_in_memory && !is_bit_op(req.op));
  endfunction

  // Single-cycle datapath shared by register and memory operands.
  function automatic alu_resp_t execute(input op_t               op,
                                        input logic [DATA_W-1:0] operand,
                                        input logic [DATA_W-1:0] second,
                                        input logic [BIT_W-1:0]  idx,
                                        input logic              carry_in);
    alu_resp_t         r;
    logic [DATA_W-1:0] mask;
    logic              sel;
    r    = RESP_RST;
    mask = BIT_ONE_MASK << idx;
    sel  = operand[idx];
    unique case (op)
      logic_and: begin
        r.value     = operand & second;
        r.reg_write = 1'b1;
      end
      logic_or: begin
        r.value     = operand | second;
        r.reg_write = 1'b1;
      end
      logic_xor: begin
        r.value     = operand ^ second;
        r.reg_write = 1'b1;
      end
      logic_not: begin
        r.value     = ~operand;
        r.reg_write = 1'b1;
      end
      shift_arith_left, shift_logic_left: begin
        r.value       = {operand[DATA_W-2:0], 1'b0};
        r.carry       = operand[DATA_W-1];
        r.reg_write   = 1'b1;
        r.carry_write = 1'b1;
      end
      shift_arith_right: begin
        r.value       = {operand[DATA_W-1], operand[DATA_W-1:1]};
        r.carry       = operand[0];
        r.reg_write   = 1'b1;
        r.carry_write = 1'b1;
      end
      shift_logic_right: begin
        r.value       = {1'b0, operand[DATA_W-1:1]};
        r.carry       = operand[0];
        r.reg_write   = 1'b1;
        r.carry_write = 1'b1;
      end
      rotate_left: begin
        r.value       = {operand[DATA_W-2:0], operand[DATA_W-1]};
        r.carry       = operand[DATA_W-1];
        r.reg_write   = 1'b1;
        r.carry_write = 1'b1;
      end
      rotate_right: begin
        r.value       = {operand[0], operand[DATA_W-1:1]};
        r.carry       = operand[0];
        r.reg_write   = 1'b1;
        r.carry_write = 1'b1;
      end
      rotate_carry_left: begin
        r.value       = {operand[DATA_W-2:0], carry_in};
        r.carry       = operand[DATA_W-1];
        r.reg_write   = 1'b1;
        r.carry_write = 1'b1;
      end
      rotate_carry_right: begin
        r.value       = {carry_in, operand[DATA_W-1:1]};
        r.carry       = operand[0];
        r.reg_write   = 1'b1;
        r.carry_write = 1'b1;
      end
      set_selected_bit: begin
        r.value     = operand | mask;
        r.reg_write = 1'b1;
      end
      clear_selected_bit: begin
        r.value     = operand & ~mask;
        r.reg_write = 1'b1;
      end
      invert_selected_bit: begin
        r.value     = operand ^ mask;
        r.reg_write = 1'b1;
      end
      test_selected_bit: begin
        r.value      = operand;
        r.zero       = ~sel;
        r.zero_write = 1'b1;
      end
      carry_and_bit: begin
        r.value       = operand;
        r.carry       = carry_in & sel;
        r.carry_write = 1'b1;
      end
      carry_and_inverted_bit: begin
        r.value       = operand;
        r.carry       = carry_in & ~sel;
        r.carry_write = 1'b1;
      end
      carry_or_bit: begin
        r.value       = operand;
        r.carry       = carry_in | sel;
        r.carry_write = 1'b1;
      end
      carry_or_inverted_bit: begin
        r.value       = operand;
        r.carry       = carry_in | ~sel;
        r.carry_write = 1'b1;
      end
      carry_xor_bit: begin
        r.value       = operand;
        r.carry       = carry_in ^ sel;
        r.carry_write = 1'b1;
      end
      carry_xor_inverted_bit: begin
        r.value       = operand;
        r.carry       = carry_in ^ ~sel;
        r.carry_write = 1'b1;
      end
      load_bit_to_carry: begin
        r.value       = operand;
        r.carry       = sel;
        r.carry_write = 1'b1;
      end
      load_inverted_bit_to_carry: begin
        r.value       = operand;
        r.carry       = ~sel;
        r.carry_write = 1'b1;
      end
      store_carry_to_bit: begin
        r.value     = carry_in ? (operand | mask) : (operand & ~mask);
        r.reg_write = 1'b1;
      end
      store_inverted_carry_to_bit: begin
        r.value     = carry_in ? (operand & ~mask) : (operand | mask);
        r.reg_write = 1'b1;
      end
      default: begin
        r.illegal = 1'b1;
      end
    endcase
    return r;
  endfunction

  state_t            state_reg;
  alu_req_t          req_reg;
  alu_resp_t         resp_reg;
  logic              resp_valid_reg;
  logic              mem_valid_reg;
  mem_cmd_t          mem_cmd_reg;

  alu_req_t          req_sel;
  logic [DATA_W-1:0] operand_sel;
  logic [DATA_W-1:0] second_sel;
  logic [BIT_W-1:0]  idx_sel;
  alu_resp_t         exec;
  logic              take;
  logic              take_illegal;
  logic              take_memory;
  logic              read_done;
  logic              write_done;

  assign o_req_ready  = (state_reg == st_idle);
  assign take         = i_req_valid && o_req_ready;
  assign take_illegal = take && is_illegal(i_req);
  assign take_memory  = take && !take_illegal && i_req.operand_in_memory;
  assign read_done    = (state_reg == st_mem_read) && i_mem_ack;
  assign write_done   = (state_reg == st_mem_write) && i_mem_ack;

  // A memory operand is evaluated on the byte returned by the read.
  always_comb begin
    req_sel     = (state_reg == st_idle) ? i_req : req_reg;
    operand_sel = (state_reg == st_mem_read) ? i_mem_rdata : req_sel.dest_value;
    second_sel  = req_sel.use_immediate ? req_sel.immediate_byte : req_sel.source_register;
    idx_sel     = req_sel.bit_from_register ? req_sel.source_register[BIT_W-1:0]
                                            : req_sel.bit_index;
    exec        = execute(req_sel.op, operand_sel, second_sel, idx_sel, req_sel.carry_in);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg <= st_idle;
    end else begin
      unique case (state_reg)
        st_idle: begin
          if (take_memory) begin
            state_reg <= st_mem_read;
          end
        end
        st_mem_read: begin
          if (i_mem_ack) begin
            state_reg <= modifies_operand(req_reg.op) ? st_mem_write : st_idle;
          end
        end
        st_mem_write: begin
          if (i_mem_ack) begin
            state_reg <= st_idle;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      req_reg <= '0;
    end else if (take) begin
      req_reg <= i_req;
    end
  end

  // The byte is read whole; for operations that change it, one bit is altered and the whole byte is written back.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mem_valid_reg <= 1'b0;
      mem_cmd_reg   <= MEM_RST;
    end else if (take_memory) begin
      mem_valid_reg <= 1'b1;
      mem_cmd_reg   <= '{write: 1'b0, addr: i_req.mem_addr, wdata: BYTE_RST};
    end else if (read_done) begin
      mem_valid_reg <= modifies_operand(req_reg.op);
      mem_cmd_reg   <= '{write: modifies_operand(req_reg.op), addr: req_reg.mem_addr,
                         wdata: exec.value};
    end else if (write_done) begin
      mem_valid_reg <= 1'b0;
      mem_cmd_reg   <= MEM_RST;
    end
  end

  // Memory results never write a register; a modified byte goes back to memory instead.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      resp_reg <= RESP_RST;
    end else if (take_illegal) begin
      resp_reg         <= RESP_RST;
      resp_reg.illegal <= 1'b1;
    end else if (take && !take_memory) begin
      resp_reg <= exec;
    end else if (read_done) begin
      resp_reg           <= exec;
      resp_reg.reg_write <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      resp_valid_reg <= 1'b0;
    end else begin
      resp_valid_reg <= (take && !take_memory) ||
                        (read_done && !modifies_operand(req_reg.op)) ||
                        write_done;
    end
  end

  assign o_resp_valid = resp_valid_reg;
  assign o_resp       = resp_reg;
  assign o_mem_valid  = mem_valid_reg;
  assign o_mem_cmd    = mem_cmd_reg;

endmodule // logic_shift_bit_unit

// >>> hw/logic_shift_bit_pkg.sv
// Shared types and constants for the byte-wide logic, shift and bit-manipulation unit.
// Assumes the instruction decoder fills a request struct and the register file applies results.
package logic_shift_bit_pkg;

  localparam int DATA_W = 8;
  localparam int BIT_W  = 3;
  localparam int ADDR_W = 16;

  localparam logic [DATA_W-1:0] BYTE_RST     = 8'h00;
  localparam logic [DATA_W-1:0] BIT_ONE_MASK = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_RST     = 16'h0000;

  // Operations executed by the unit.
  typedef enum logic [4:0] {
    logic_and,
    logic_or,
    logic_xor,
    logic_not,
    shift_arith_left,
    shift_arith_right,
    shift_logic_left,
    shift_logic_right,
    rotate_left,
    rotate_right,
    rotate_carry_left,
    rotate_carry_right,
    set_selected_bit,
    clear_selected_bit,
    invert_selected_bit,
    test_selected_bit,
    carry_and_bit,
    carry_and_inverted_bit,
    carry_or_bit,
    carry_or_inverted_bit,
    carry_xor_bit,
    carry_xor_inverted_bit,
    load_bit_to_carry,
    load_inverted_bit_to_carry,
    store_carry_to_bit,
    store_inverted_carry_to_bit
  } op_t;

  // One instruction as handed over by the decoder.
  typedef struct packed {
    op_t               op;
    logic              use_immediate;
    logic              operand_in_memory;
    logic              bit_from_register;
    logic [DATA_W-1:0] dest_value;
    logic [DATA_W-1:0] source_register;
    logic [DATA_W-1:0] immediate_byte;
    logic [BIT_W-1:0]  bit_index;
    logic [ADDR_W-1:0] mem_addr;
    logic              carry_in;
  } alu_req_t;

  // Result of one instruction.
  typedef struct packed {
    logic [DATA_W-1:0] value;
    logic              reg_write;
    logic              carry;
    logic              carry_write;
    logic              zero;
    logic              zero_write;
    logic              illegal;
  } alu_resp_t;

  // One byte access to data memory.
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_cmd_t;

  localparam alu_resp_t RESP_RST = '{value: BYTE_RST, reg_write: 1'b0, carry: 1'b0,
                                     carry_write: 1'b0, zero: 1'b0, zero_write: 1'b0,
                                     illegal: 1'b0};
  localparam mem_cmd_t  MEM_RST  = '{write: 1'b0, addr: ADDR_RST, wdata: BYTE_RST};

endpackage : logic_shift_bit_pkg

// >>> tb/lsb_monitor.sv
// Port checker for the logic, shift and bit unit.
// Assumes it is bound into every instance of the unit and sees only its ports.
module lsb_monitor
  import logic_shift_bit_pkg::*;
(
  input wire logic              i_core_clk,
  input wire logic              i_rst,
  input wire logic              i_req_valid,
  input wire logic              o_req_ready,
  input wire alu_req_t          i_req,
  input wire logic              o_resp_valid,
  input wire alu_resp_t         o_resp,
  input wire logic              o_mem_valid,
  input wire mem_cmd_t          o_mem_cmd,
  input wire logic              i_mem_ack,
  input wire logic [DATA_W-1:0] i_mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic take;
  logic reg_take;
  assign take     = i_req_valid && o_req_ready;
  assign reg_take = take && !i_req.operand_in_memory;

  property p_reg_answer;
    reg_take |=> o_resp_valid;
  endproperty
  a_reg_answer: assert property (p_reg_answer) else $error("register op not answered");
  property p_not;
    reg_take && i_req.op == logic_not |=>
      o_resp.reg_write && o_resp.value == ~$past(i_req.dest_value);
  endproperty
  a_not: assert property (p_not) else $error("complement wrong");
  property p_rcl;
    reg_take && i_req.op == rotate_carry_left |=> o_resp.carry == $past(i_req.dest_value[7])
      && o_resp.value == {$past(i_req.dest_value[6:0]), $past(i_req.carry_in)};
  endproperty
  a_rcl: assert property (p_rcl) else $error("rotate through carry wrong");
  property p_set;
    reg_take && i_req.op == set_selected_bit && !i_req.bit_from_register |=>
      o_resp.value == ($past(i_req.dest_value) | (BIT_ONE_MASK << $past(i_req.bit_index)));
  endproperty
  a_set: assert property (p_set) else $error("set bit wrong");
  property p_test;
    reg_take && i_req.op == test_selected_bit && !i_req.bit_from_register |=>
      o_resp.zero_write && o_resp.zero == !$past(i_req.dest_value[i_req.bit_index]);
  endproperty
  a_test: assert property (p_test) else $error("test bit zero flag wrong");
  property p_inv_reg;
    take && i_req.bit_from_register && i_req.op inside {carry_and_inverted_bit,
      carry_or_inverted_bit, carry_xor_inverted_bit, load_inverted_bit_to_carry,
      store_inverted_carry_to_bit} |=> o_resp.illegal && !o_resp.carry_write && !o_resp.reg_write;
  endproperty
  a_inv_reg: assert property (p_inv_reg) else $error("register bit number accepted");
  property p_mem_read;
    take && i_req.operand_in_memory && i_req.op inside {[set_selected_bit:test_selected_bit]}
      |=> o_mem_valid && !o_mem_cmd.write && o_mem_cmd.addr == $past(i_req.mem_addr);
  endproperty
  a_mem_read: assert property (p_mem_read) else $error("memory read not issued");
  property p_mem_hold;
    o_mem_valid && !i_mem_ack |=> o_mem_valid && $stable(o_mem_cmd);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory command moved");
  property p_rmw;
    o_mem_valid && i_mem_ack && !o_mem_cmd.write |=> (o_resp_valid && !o_mem_valid) ||
      (o_mem_valid && o_mem_cmd.write && o_mem_cmd.addr == $past(o_mem_cmd.addr)
       && $onehot0(o_mem_cmd.wdata ^ $past(i_mem_rdata)));
  endproperty
  a_rmw: assert property (p_rmw) else $error("read-modify-write wrong");
  property p_write_end;
    o_mem_valid && i_mem_ack && o_mem_cmd.write |=>
      o_resp_valid && !o_mem_valid && !o_resp.reg_write;
  endproperty
  a_write_end: assert property (p_write_end) else $error("write end wrong");
endmodule // lsb_monitor

bind logic_shift_bit_unit lsb_monitor u_mon (.i_core_clk, .i_rst, .i_req_valid, .o_req_ready,
  .i_req, .o_resp_valid, .o_resp, .o_mem_valid, .o_mem_cmd, .i_mem_ack, .i_mem_rdata);

// >>> tb/mem_partner.sv
// Byte memory answering the unit's memory commands after a set number of wait cycles.
// Assumes the command stays stable until acknowledged; only the low four address bits count.
module mem_partner
  import logic_shift_bit_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic              i_mem_valid,
  input  wire mem_cmd_t          i_mem_cmd,
  input  wire logic [3:0]        i_wait,
  output logic                   o_mem_ack,
  output logic [DATA_W-1:0]      o_mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [16];
  logic [3:0]        wait_reg;
  initial for (int k = 0; k < 16; k++) mem[k] = 8'h96 ^ 8'(k);
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_mem_valid || o_mem_ack) wait_reg <= 4'h0;
    else wait_reg <= wait_reg + 4'h1;
  end
  assign o_mem_ack = i_mem_valid && (wait_reg >= i_wait);
  // Outside an acknowledge the read data shows the inverse byte, so nothing stale passes.
  assign o_mem_rdata = o_mem_ack ? mem[i_mem_cmd.addr[3:0]] : ~mem[i_mem_cmd.addr[3:0]];
  always @(posedge i_core_clk) begin
    if (o_mem_ack && i_mem_cmd.write) mem[i_mem_cmd.addr[3:0]] <= i_mem_cmd.wdata;
  end
endmodule // mem_partner

// >>> tb/tb_top.sv
// Self-checking bench for the logic, shift and bit unit with a memory partner.
// Assumes the checker is bound in and inputs change at the falling clock edge.
module tb_top
  import logic_shift_bit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {op_t op; logic m; logic c; logic [2:0] b; logic [7:0] d; logic [7:0] s;
                  logic [7:0] v; logic f;} row_t;
  logic              i_core_clk = 1'h0;
  logic              i_rst = 1'h1;
  logic              i_req_valid = 1'h0;
  alu_req_t          i_req = '0;
  logic [3:0]        mem_wait = 4'h0;
  logic              o_req_ready, o_resp_valid, o_mem_valid, i_mem_ack;
  alu_resp_t         o_resp;
  mem_cmd_t          o_mem_cmd;
  logic [DATA_W-1:0] i_mem_rdata;
  int                error_cnt = 0, samples_checked = 0, cycles = 0, n;
  row_t rows[29] = '{
    '{logic_and, 1'h0, 1'h0, 3'h0, 8'hA5, 8'h3C, 8'h24, 1'h0},
    '{logic_and, 1'h1, 1'h0, 3'h0, 8'hA5, 8'h0F, 8'h05, 1'h0},
    '{logic_or, 1'h1, 1'h0, 3'h0, 8'hA5, 8'h0A, 8'hAF, 1'h0},
    '{logic_xor, 1'h0, 1'h0, 3'h0, 8'hA5, 8'h3C, 8'h99, 1'h0},
    '{logic_not, 1'h0, 1'h0, 3'h0, 8'hA5, 8'h00, 8'h5A, 1'h0},
    '{shift_arith_left, 1'h0, 1'h0, 3'h0, 8'hA5, 8'h00, 8'h4A, 1'h1},
    '{shift_arith_right, 1'h0, 1'h0, 3'h0, 8'hA5, 8'h00, 8'hD2, 1'h1},
    '{shift_logic_left, 1'h0, 1'h1, 3'h0, 8'h65, 8'h00, 8'hCA, 1'h0},
    '{shift_logic_right, 1'h0, 1'h0, 3'h0, 8'hA5, 8'h00, 8'h52, 1'h1},
    '{rotate_left, 1'h0, 1'h0, 3'h0, 8'hA5, 8'h00, 8'h4B, 1'h1},
    '{rotate_right, 1'h0, 1'h1, 3'h0, 8'hA4, 8'h00, 8'h52, 1'h0},
    '{rotate_carry_left, 1'h0, 1'h0, 3'h0, 8'hA5, 8'h00, 8'h4A, 1'h1},
    '{rotate_carry_right, 1'h0, 1'h1, 3'h0, 8'hA4, 8'h00, 8'hD2, 1'h0},
    '{set_selected_bit, 1'h0, 1'h0, 3'h1, 8'hA5, 8'h00, 8'hA7, 1'h0},
    '{set_selected_bit, 1'h1, 1'h0, 3'h0, 8'hA5, 8'h04, 8'hAD, 1'h0},
    '{clear_selected_bit, 1'h0, 1'h0, 3'h7, 8'hA5, 8'h00, 8'h25, 1'h0},
    '{invert_selected_bit, 1'h0, 1'h0, 3'h0, 8'hA5, 8'h00, 8'hA4, 1'h0},
    '{test_selected_bit, 1'h0, 1'h0, 3'h1, 8'hA5, 8'h00, 8'h00, 1'h1},
    '{test_selected_bit, 1'h0, 1'h0, 3'h2, 8'hA5, 8'h00, 8'h00, 1'h0},
    '{carry_and_bit, 1'h0, 1'h1, 3'h2, 8'hA5, 8'h00, 8'h00, 1'h1},
    '{carry_and_inverted_bit, 1'h0, 1'h1, 3'h1, 8'hA5, 8'h00, 8'h00, 1'h1},
    '{carry_or_bit, 1'h0, 1'h0, 3'h0, 8'hA5, 8'h00, 8'h00, 1'h1},
    '{carry_or_inverted_bit, 1'h0, 1'h0, 3'h0, 8'hA5, 8'h00, 8'h00, 1'h0},
    '{carry_xor_bit, 1'h0, 1'h1, 3'h0, 8'hA5, 8'h00, 8'h00, 1'h0},
    '{carry_xor_inverted_bit, 1'h0, 1'h0, 3'h1, 8'hA5, 8'h00, 8'h00, 1'h1},
    '{load_bit_to_carry, 1'h0, 1'h0, 3'h7, 8'hA5, 8'h00, 8'h00, 1'h1},
    '{load_inverted_bit_to_carry, 1'h0, 1'h1, 3'h7, 8'hA5, 8'h00, 8'h00, 1'h0},
    '{store_carry_to_bit, 1'h0, 1'h1, 3'h1, 8'hA5, 8'h00, 8'hA7, 1'h0},
    '{store_inverted_carry_to_bit, 1'h0, 1'h1, 3'h0, 8'hA5, 8'h00, 8'hA4, 1'h0}};
  // Memory byte 2 starts at 8'h94; each row leaves the byte that the next one reads.
  row_t mrows[6] = '{
    '{set_selected_bit, 1'h0, 1'h0, 3'h0, 8'h00, 8'h00, 8'h95, 1'h0},
    '{clear_selected_bit, 1'h0, 1'h0, 3'h7, 8'h00, 8'h00, 8'h15, 1'h0},
    '{invert_selected_bit, 1'h1, 1'h0, 3'h0, 8'h00, 8'h05, 8'h11, 1'h0},
    '{test_selected_bit, 1'h0, 1'h0, 3'h4, 8'h00, 8'h00, 8'h11, 1'h0},
    '{load_inverted_bit_to_carry, 1'h0, 1'h1, 3'h0, 8'h00, 8'h00, 8'h11, 1'h0},
    '{store_inverted_carry_to_bit, 1'h0, 1'h0, 3'h1, 8'h00, 8'h00, 8'h13, 1'h0}};

  logic_shift_bit_unit dut (.i_core_clk, .i_rst, .i_req_valid, .o_req_ready, .i_req,
    .o_resp_valid, .o_resp, .o_mem_valid, .o_mem_cmd, .i_mem_ack, .i_mem_rdata);
  mem_partner u_mem (.i_core_clk, .i_rst, .i_mem_valid(o_mem_valid), .i_mem_cmd(o_mem_cmd),
    .i_wait(mem_wait), .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));

  always #2.5 i_core_clk = ~i_core_clk;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic drive(input row_t r, input logic mem);
    alu_req_t q;
    q = '0;
    q.op = r.op;
    q.use_immediate = r.m;
    q.bit_from_register = r.m && r.op > rotate_carry_right;
    q.operand_in_memory = mem;
    q.dest_value = r.d;
    q.source_register = r.m ? ~r.s : r.s;
    q.immediate_byte = r.s;
    q.bit_index = r.b;
    q.carry_in = r.c;
    q.mem_addr = 16'h0002;
    i_req = q;
    i_req_valid = 1'h1;
  endtask

  task automatic chk_row(input row_t r);
    check(8'(o_resp_valid), 8'h01);
    if (r.op < test_selected_bit || r.op > load_inverted_bit_to_carry)
      check(o_resp.value, r.v);
    if ((r.op >= shift_arith_left && r.op <= rotate_carry_right) ||
        (r.op > test_selected_bit && r.op < store_carry_to_bit))
      check(8'(o_resp.carry), 8'(r.f));
    if (r.op == test_selected_bit) check(8'(o_resp.zero), 8'(r.f));
  endtask

  initial begin
    repeat (5) @(negedge i_core_clk);
    check(8'({o_req_ready, o_resp_valid, o_mem_valid}), 8'h04);
    check(o_resp.value, 8'h00);
    i_rst = 1'h0;
    drive(rows[0], 1'h0);
    for (int k = 1; k <= 29; k++) begin
      @(negedge i_core_clk);
      chk_row(rows[k - 1]);
      if (k < 29) drive(rows[k], 1'h0);
    end
    $display("register rows done");
    drive('{carry_and_inverted_bit, 1'h1, 1'h1, 3'h0, 8'hA5, 8'h01, 8'h00, 1'h0}, 1'h0);
    @(negedge i_core_clk);
    check(8'({o_resp.illegal, o_resp.carry_write}), 8'h02);
    drive('{logic_and, 1'h0, 1'h0, 3'h0, 8'hA5, 8'h3C, 8'h00, 1'h0}, 1'h1);
    @(negedge i_core_clk);
    check(8'({o_resp.illegal, o_mem_valid}), 8'h02);
    $display("illegal cases done");
    for (int k = 0; k < 6; k++) begin
      mem_wait = k[0] ? 4'h3 : 4'h0;
      drive(mrows[k], 1'h1);
      @(negedge i_core_clk);
      i_req_valid = 1'h0;
      n = 0;
      while (o_resp_valid !== 1'h1 && n < 40) begin
        @(negedge i_core_clk);
        n++;
      end
      chk_row(mrows[k]);
      check(u_mem.mem[2], mrows[k].v);
      check(8'(o_resp.reg_write), 8'h00);
    end
    $display("memory rows done");
    // Reset lands while a memory read waits; the byte must stay untouched.
    mem_wait = 4'h3;
    drive(mrows[0], 1'h1);
    @(negedge i_core_clk);
    i_req_valid = 1'h0;
    @(negedge i_core_clk);
    check(8'({o_mem_valid, o_mem_cmd.write}), 8'h02);
    i_rst = 1'h1;
    @(negedge i_core_clk);
    i_rst = 1'h0;
    check(8'({o_req_ready, o_resp_valid, o_mem_valid}), 8'h04);
    check(o_resp.value, 8'h00);
    check(u_mem.mem[2], 8'h13);
    drive(rows[0], 1'h0);
    @(negedge i_core_clk);
    i_req_valid = 1'h0;
    chk_row(rows[0]);
    $display("mid-run reset done");
    finish_test();
  end
endmodule // tb_top
